// file: inc/lhi_pkg.sv
// package: constants and types for the lcd driver host interface
package lhi_pkg;
  localparam int          DATA_W      = 8;
  localparam int          FIFO_DEPTH  = 32;
  localparam int          BIT_CNT_W   = 3;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [2:0]  BIT_FIRST   = 3'h0;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  // fifo word: {isData, byte}
  localparam int          WORD_W      = DATA_W + 1;
  localparam int          WORD_DATA_BIT = DATA_W;

  typedef enum logic [1:0]
  {
    LHI_IDLE   = 2'b00,
    LHI_WRITE  = 2'b01,
    LHI_READ   = 2'b10
  } lhi_acc_t;
endpackage

// file: rtl/lhi_fifo.sv
// file: synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module lhi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_r] <= inData;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      if (pop)
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_count: assert property (@(posedge clk) disable iff (sys_rst)
    count_r <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

// file: rtl/lhi_host_port.sv
// file: host port of the lcd driver, parallel 68/80 and serial write
`timescale 1ns/1ps
module lhi_host_port #(
  parameter int DATA_W = 8,
  parameter int DEPTH  = 32
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              parallelSel,
  input  wire logic              busStyleSelect,
  input  wire logic              chipSelectLow_n,
  input  wire logic              chipSelectHigh,
  input  wire logic              dataCommandSelect,
  input  wire logic              readStrobe,
  input  wire logic              writeStrobe,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic      [DATA_W-1:0] dataOe,
  input  wire logic              serialClk,
  input  wire logic [DATA_W-1:0] readData,
  input  wire logic [DATA_W-1:0] statusData,
  output logic                   readReq,
  output logic      [DATA_W-1:0] byteOut,
  output logic                   byteIsData,
  output logic                   byteValid,
  input  wire logic              byteReady,
  output logic                   overflow
);
  ////////////////////////////////////////////////////////////////////////////
  logic              chipOn;
  logic              serMode;
  logic              rdAct;
  logic              wrAct;
  logic              rdAct_r;
  logic              wrAct_r;
  logic              sclk_r;
  logic [DATA_W-1:0] shift_r;
  logic [2:0]        bitCnt_r;
  logic [DATA_W-1:0] holdLatch_r;
  logic [DATA_W-1:0] dataOut_r;
  logic [DATA_W-1:0] dataOe_r;
  logic              readReq_r;
  logic              overflow_r;
  logic              pWrite;
  logic              sWrite;
  logic              fifoValid;
  logic              fifoReady;
  logic [lhi_pkg::WORD_W-1:0] fifoIn;
  logic [lhi_pkg::WORD_W-1:0] fifoOut;
  logic [DATA_W-1:0] sWord;
  lhi_pkg::lhi_acc_t acc;

  assign chipOn  = !chipSelectLow_n && chipSelectHigh;
  assign serMode = !parallelSel;

  // direction decode per bus style
  always_comb
  begin
    if (busStyleSelect)
    begin
      rdAct = readStrobe && writeStrobe;
      wrAct = readStrobe && !writeStrobe;
    end
    else
    begin
      rdAct = !readStrobe;
      wrAct = !writeStrobe;
    end
  end

  always_comb
  begin
    if (!chipOn || serMode)
      acc = lhi_pkg::LHI_IDLE;
    else if (wrAct)
      acc = lhi_pkg::LHI_WRITE;
    else if (rdAct && dataCommandSelect)
      acc = lhi_pkg::LHI_READ;
    else
      acc = lhi_pkg::LHI_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel strobe tracking; trailing edge takes the byte
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdAct_r <= 1'b0;
      wrAct_r <= 1'b0;
    end
    else
    begin
      rdAct_r <= (acc == lhi_pkg::LHI_READ);
      wrAct_r <= (acc == lhi_pkg::LHI_WRITE);
    end
  end

  // write ends when strobe drops or chip deselects mid-cycle
  assign pWrite = wrAct_r && (acc != lhi_pkg::LHI_WRITE);

  // latch the bus each cycle the write is active, commit at trailing edge
  logic [DATA_W-1:0] pData_r;
  logic              pIsData_r;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pData_r   <= lhi_pkg::BYTE_ZERO;
      pIsData_r <= 1'b0;
    end
    else if (acc == lhi_pkg::LHI_WRITE)
    begin
      pData_r   <= dataIn;
      pIsData_r <= dataCommandSelect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial receiver; scl sampled as a synchronous input
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sclk_r <= 1'b0;
    else
      sclk_r <= serialClk;
  end

  logic sclkRise;
  assign sclkRise = serialClk && !sclk_r && chipOn && serMode;
  assign sWord    = {shift_r[DATA_W-2:0], dataIn[DATA_W-1]};
  assign sWrite   = sclkRise && (bitCnt_r == lhi_pkg::BIT_LAST);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_r  <= lhi_pkg::BYTE_ZERO;
      bitCnt_r <= lhi_pkg::BIT_FIRST;
    end
    else if (!chipOn || !serMode)
    begin
      shift_r  <= lhi_pkg::BYTE_ZERO;
      bitCnt_r <= lhi_pkg::BIT_FIRST;
    end
    else if (sclkRise)
    begin
      shift_r  <= sWord;
      bitCnt_r <= bitCnt_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // both paths feed the fifo; select sampled with the final bit
  always_comb
  begin
    if (sWrite)
      fifoIn = {dataCommandSelect, sWord};
    else
      fifoIn = {pIsData_r, pData_r};
  end
  assign fifoValid = sWrite || pWrite;

  // fifo absorbs bursts so the host never waits; overflow is sticky
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      overflow_r <= 1'b0;
    else if (fifoValid && !fifoReady)
      overflow_r <= 1'b1;
  end

  lhi_fifo #(
    .WIDTH (lhi_pkg::WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inData   (fifoIn),
    .inValid  (fifoValid),
    .inReady  (fifoReady),
    .outData  (fifoOut),
    .outValid (byteValid),
    .outReady (byteReady)
  );

  assign byteOut    = fifoOut[DATA_W-1:0];
  assign byteIsData = fifoOut[lhi_pkg::WORD_DATA_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // read path: bus shows the holding latch, refilled at end of read
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      holdLatch_r <= lhi_pkg::STATUS_RST;
      readReq_r   <= 1'b0;
    end
    else
    begin
      readReq_r <= rdAct_r && (acc != lhi_pkg::LHI_READ);
      if (readReq_r)
        holdLatch_r <= readData;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dataOut_r <= lhi_pkg::BYTE_ZERO;
      dataOe_r  <= '0;
    end
    else if (acc == lhi_pkg::LHI_READ)
    begin
      dataOut_r <= holdLatch_r;
      dataOe_r  <= '1;
    end
    else
    begin
      dataOut_r <= statusData;
      dataOe_r  <= '0;
    end
  end

  assign dataOut  = dataOut_r;
  assign dataOe   = dataOe_r;
  assign readReq  = readReq_r;
  assign overflow = overflow_r;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_lastEdge;
    sclkRise && bitCnt_r == lhi_pkg::BIT_LAST;
  endsequence

  a_serial_byte: assert property (@(posedge clk) disable iff (sys_rst)
    s_lastEdge |-> fifoValid && fifoIn[DATA_W-1:0] == sWord)
    else $error("serial byte not delivered on eighth edge");
  a_serial_noread: assert property (@(posedge clk) disable iff (sys_rst)
    serMode |=> dataOe == '0)
    else $error("bus driven in serial mode");
  a_deselect_float: assert property (@(posedge clk) disable iff (sys_rst)
    !chipOn |=> dataOe == '0)
    else $error("bus driven while deselected");
  a_deselect_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !chipOn |=> bitCnt_r == lhi_pkg::BIT_FIRST)
    else $error("counter not cleared on deselect");
  a_select_sample: assert property (@(posedge clk) disable iff (sys_rst)
    s_lastEdge |-> fifoIn[lhi_pkg::WORD_DATA_BIT] == dataCommandSelect)
    else $error("select not sampled with last bit");
  a_msb_first: assert property (@(posedge clk) disable iff (sys_rst)
    sclkRise |=> shift_r[0] == $past(dataIn[DATA_W-1]))
    else $error("serial bit order wrong");
  a_write_trail: assert property (@(posedge clk) disable iff (sys_rst)
    (acc == lhi_pkg::LHI_WRITE) ##1 (acc != lhi_pkg::LHI_WRITE)
      |-> fifoValid)
    else $error("write not taken at trailing edge");
  a_read_drive: assert property (@(posedge clk) disable iff (sys_rst)
    (acc == lhi_pkg::LHI_READ) |=>
      dataOe == '1 && dataOut == $past(holdLatch_r))
    else $error("read does not show holding latch");
  a_chip_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !chipOn |-> acc == lhi_pkg::LHI_IDLE)
    else $error("access decoded while deselected");
endmodule

// file: verif/lhi_host_model.sv
// host processor model: parallel 68/80 bus and serial link
`timescale 1ns/1ps
module lhi_host_model (
  input  wire logic       clk,
  input  wire logic       busStyleSelect,
  input  wire logic [7:0] dataOut,
  input  wire logic [7:0] dataOe,
  output logic            chipSelectLow_n,
  output logic            chipSelectHigh,
  output logic            dataCommandSelect,
  output logic            readStrobe,
  output logic            writeStrobe,
  output logic      [7:0] dataIn,
  output logic            serialClk
);
  initial
  begin
    chipSelectLow_n = 1'b1;
    chipSelectHigh = 1'b0;
    dataCommandSelect = 1'b0;
    readStrobe = 1'b1;
    writeStrobe = 1'b1;
    dataIn = 8'hA5;
    serialClk = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // both selects driven together; strobes parked idle for the style
  task automatic sel(input logic lo_n, input logic hi);
    @(posedge clk);
    chipSelectLow_n <= lo_n;
    chipSelectHigh <= hi;
    readStrobe <= ~busStyleSelect;
    writeStrobe <= 1'b1;
  endtask
  // data held one clock past the trailing strobe edge, then the bus is driven with the inverted byte
  task automatic wr(input logic dc, input logic [7:0] d);
    @(posedge clk);
    dataCommandSelect <= dc;
    dataIn <= d;
    writeStrobe <= 1'b0;
    if (busStyleSelect)
    begin
      readStrobe <= 1'b1;
    end
    repeat (2) @(posedge clk);
    if (busStyleSelect)
    begin
      readStrobe <= 1'b0;
    end
    else
    begin
      writeStrobe <= 1'b1;
    end
    @(posedge clk);
    writeStrobe <= 1'b1;
    dataIn <= ~d;
  endtask
  task automatic rd(input logic dc, output logic [7:0] d,
                    output logic [7:0] oe);
    @(posedge clk);
    dataCommandSelect <= dc;
    readStrobe <= busStyleSelect;
    repeat (2) @(posedge clk);
    #1;
    d = dataOut;
    oe = dataOe;
    @(posedge clk);
    readStrobe <= ~busStyleSelect;
    repeat (3) @(posedge clk);
  endtask
  // msb first, each level two clocks; clock parked low between frames
  task automatic ser(input logic dc, input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      serialClk <= 1'b0;
      dataIn[7] <= d[7-i];
      dataCommandSelect <= dc;
      @(posedge clk);
      @(posedge clk);
      serialClk <= 1'b1;
      @(posedge clk);
    end
    @(posedge clk);
    serialClk <= 1'b0;
    dataIn <= ~dataIn;
  endtask
endmodule

// file: verif/testbench.sv
// self-checking bench for the lcd host port with byte queue model
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        sys_rst, parallelSel, busStyleSelect, stall;
  logic        chipSelectLow_n, chipSelectHigh, dataCommandSelect;
  logic        readStrobe, writeStrobe, serialClk, readReq;
  logic        byteIsData, byteValid, overflow;
  logic        byteReady = 1'b0;
  logic [7:0]  dataIn, dataOut, dataOe, readData, statusData, byteOut;
  logic [7:0]  d, oe, prev;
  logic [8:0]  expQ[$];
  logic [31:0] rnd = 32'h8530;
  logic [31:0] rdyRnd = 32'h8530;
  int          n_errors = 0;
  int          check_count = 0;
  int          nReq = 0;

  always #25 clk = ~clk;

  lhi_host_port dut (.clk, .sys_rst, .parallelSel, .busStyleSelect,
    .chipSelectLow_n, .chipSelectHigh, .dataCommandSelect, .readStrobe,
    .writeStrobe, .dataIn, .dataOut, .dataOe, .serialClk, .readData,
    .statusData, .readReq, .byteOut, .byteIsData, .byteValid, .byteReady,
    .overflow);
  lhi_host_model hostMdl (.clk, .busStyleSelect, .dataOut, .dataOe,
    .chipSelectLow_n, .chipSelectHigh, .dataCommandSelect, .readStrobe,
    .writeStrobe, .dataIn, .serialClk);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // consumer stalls at random so bytes queue up in the fifo
  always @(posedge clk)
  begin
    rdyRnd = lfsr(rdyRnd);
    if (readReq === 1'b1)
      nReq++;
    byteReady <= ~stall & rdyRnd[2];
    if (byteValid === 1'b1 && byteReady === 1'b1)
    begin
      if (expQ.size() == 0)
        chk("spurious byte", 9'h1FF, {byteIsData, byteOut});
      else
        chk("byte", expQ.pop_front(), {byteIsData, byteOut});
    end
  end
  task automatic pw(input logic dc, input logic [7:0] v, input logic take);
    if (take)
      expQ.push_back({dc, v});
    hostMdl.wr(dc, v);
  endtask
  task automatic drain(input string nm);
    int k;
    k = 0;
    while (expQ.size() != 0 && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    repeat (6) @(posedge clk);
    chk("left in queue", 9'h000, 9'(expQ.size()));
    chk("valid after drain", 9'h000, {8'h00, byteValid});
    $display("test %s ended", nm);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #1000000;
    n_errors++;
    $display("watchdog expired");
    final_report;
  end
  initial
  begin
    sys_rst = 1'b1;
    parallelSel = 1'b1;
    busStyleSelect = 1'b0;
    stall = 1'b0;
    readData = 8'h00;
    statusData = 8'h00;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      busStyleSelect <= s[0];
      hostMdl.sel(1'b0, 1'b1);
      for (int i = 0; i < 6; i++)
      begin
        rnd = lfsr(rnd);
        pw(rnd[8], rnd[7:0], 1'b1);
      end
      hostMdl.sel(1'b1, 1'b1);
      pw(1'b1, 8'h3C, 1'b0);
      hostMdl.sel(1'b0, 1'b0);
      pw(1'b0, 8'hC3, 1'b0);
      hostMdl.sel(1'b0, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
        rnd = lfsr(rnd);
        readData <= rnd[7:0];
        statusData <= ~rnd[7:0];
        hostMdl.rd(1'b1, d, oe);
        if (i > 0)
          chk("read value", {1'b0, prev}, {1'b0, d});
        chk("read enable", 9'h0FF, {1'b0, oe});
        prev = rnd[7:0];
      end
      hostMdl.rd(1'b0, d, oe);
      chk("command read enable", 9'h000, {1'b0, oe});
      hostMdl.sel(1'b1, 1'b0);
      hostMdl.rd(1'b1, d, oe);
      chk("deselected enable", 9'h000, {1'b0, oe});
      chk("idle value", {1'b0, ~prev}, {1'b0, d});
      drain("parallel");
    end
    parallelSel <= 1'b0;
    busStyleSelect <= 1'b0;
    hostMdl.sel(1'b0, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      rnd = lfsr(rnd);
      expQ.push_back(rnd[8:0]);
      hostMdl.ser(rnd[8], rnd[7:0], 8);
    end
    hostMdl.ser(1'b1, 8'hF0, 5);
    hostMdl.sel(1'b1, 1'b1);
    hostMdl.sel(1'b0, 1'b1);
    expQ.push_back(9'h15A);
    hostMdl.ser(1'b1, 8'h5A, 8);
    chk("serial enable", 9'h000, {1'b0, dataOe});
    hostMdl.sel(1'b0, 1'b0);
    hostMdl.ser(1'b0, 8'h81, 8);
    drain("serial");
    parallelSel <= 1'b1;
    stall <= 1'b1;
    hostMdl.sel(1'b0, 1'b1);
    chk("overflow clear", 9'h000, {8'h00, overflow});
    for (int i = 0; i < 33; i++)
    begin
      rnd = lfsr(rnd);
      pw(1'b1, rnd[7:0], i < 32);
    end
    repeat (3) @(posedge clk);
    chk("overflow set", 9'h001, {8'h00, overflow});
    stall <= 1'b0;
    drain("fifo");
    chk("overflow sticky", 9'h001, {8'h00, overflow});
    chk("read requests", 9'h008, 9'(nReq));
    final_report;
  end
endmodule
